// ### psim_params.svh
// Register offsets, field positions, reset values and fixed counts of the segment/interleave/map block
`ifndef PSIM_PARAMS_SVH
`define PSIM_PARAMS_SVH
`define PSIM_OFF_CTRL 8'h00
`define PSIM_OFF_SIZE 8'h04
`define PSIM_OFF_GAP 8'h08
`define PSIM_OFF_STATUS 8'h0C
`define PSIM_OFF_FRAMES 8'h10
`define PSIM_CTRL_ENABLE 0
`define PSIM_CTRL_UPLINK 1
`define PSIM_CTRL_CM_EN 2
`define PSIM_SIZE_U_LSB 0
`define PSIM_SIZE_U_MSB 15
`define PSIM_SIZE_P_LSB 16
`define PSIM_SIZE_P_MSB 19
`define PSIM_GAP_FIRST_LSB 0
`define PSIM_GAP_FIRST_MSB 3
`define PSIM_GAP_LEN_LSB 4
`define PSIM_GAP_LEN_MSB 8
`define PSIM_RST_CTRL 32'h0000_0000
`define PSIM_RST_SIZE 32'h0001_001E
`define PSIM_RST_GAP 32'h0000_0000
`define PSIM_COLS 30
`define PSIM_SLOTS 15
`endif

// ### psim_pkg.sv
// Types and the column permutation table of the segment/interleave/map block
package psim_pkg;
  typedef enum logic [1:0] {
    PSIM_IDLE = 2'b00,
    PSIM_FILL = 2'b01,
    PSIM_DRAIN = 2'b10
  } psim_state_t;
  typedef logic [4:0] psim_col_t;
  // Original column taken by each permuted column
  localparam psim_col_t PSIM_PERM [30] = '{
    5'h00, 5'h14, 5'h0A, 5'h05, 5'h0F, 5'h19, 5'h03, 5'h0D, 5'h17, 5'h08,
    5'h12, 5'h1C, 5'h01, 5'h0B, 5'h15, 5'h06, 5'h10, 5'h1A, 5'h04, 5'h0E,
    5'h18, 5'h13, 5'h09, 5'h1D, 5'h0C, 5'h02, 5'h07, 5'h16, 5'h1B, 5'h11};
endpackage

// ### psim_top.sv
// Physical channel segmentation, second interleaving and slot mapping with an AHB-Lite register slave
// What this block does
// - Frame input split into channel_count consecutive groups of U bits, channel 1 first.
// - All channels share one spreading factor, so U is one value for all.
// - Uplink input is the multiplexed sequence itself, Y equals S.
// - Downlink takes S bits (fixed) or channel_count times U bits with DTX (flexible).
// - Interleaver matrix has exactly 30 columns numbered 0 to 29.
// - Row count is the least integer with rows times 30 at least U.
// - Bits are written into the matrix row by row.
// - Permuted column j takes original column P(j) from the fixed table.
// - Output is read column by column, top to bottom.
// - Positions beyond U are pruned so exactly U bits leave per channel.
// - Each channel's bits go out in ascending output index.
// - Gap within one frame: slots gap_first_slot to gap_last_slot carry no bits.
// - Gap over 15: slots first..14 empty now, slots 0..last empty next frame.
// - Uplink channels are sent full or not at all, except compressed-mode gaps.
// - Downlink channels may be partly empty; DTX indication bits are never sent.
// - RACH uses one channel, so segmentation passes bits unchanged and U equals S.
// - RACH interval is always 10 ms, one radio frame.
// - BCH uses one transport channel, one block and one physical channel.
// - PCH interval is 10 ms and FACH/PCH uses exactly one physical channel.
// - DSCH carries one transport channel only.
// - DTX indication is a third bit value that is never transmitted.
//
// The register offsets and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`include "psim_params.svh"
module psim_top import psim_pkg::*; #(
  parameter int MAX_CH = 6,
  parameter int MAX_U = 2400
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Multiplexed bit stream from upstream
  input wire logic in_valid,
  output logic in_ready,
  input wire logic in_bit,
  input wire logic in_dtx,
  // Mapped bit stream towards the transmit chain
  output logic out_valid,
  input wire logic out_ready,
  output logic out_bit,
  output logic out_tx,
  output logic [3:0] out_chan,
  output logic [3:0] out_slot
);
  localparam int UW = $clog2(MAX_U + 1);
  localparam int KW = UW + 1;
  localparam int AW = $clog2(MAX_CH * MAX_U);
  localparam logic [KW-1:0] COLS_K = KW'(`PSIM_COLS);
  localparam logic [UW-1:0] SLOTS_U = UW'(`PSIM_SLOTS);
  localparam logic [4:0] LAST_COL = 5'(`PSIM_COLS - 1);
  localparam logic [4:0] SLOTS_5 = 5'(`PSIM_SLOTS);

  psim_state_t state_q;
  logic [31:0] ctrl_q, size_q, gap_q;
  logic [15:0] frames_q;
  logic ap_wr_q;
  logic [7:0] ap_addr_q;
  logic [31:0] hrdata_q;
  logic [UW-1:0] u_q, rows, wr_k_q, rd_row_q, slot_acc_q;
  logic [3:0] p_q, wr_ch_q, rd_ch_q, out_chan_q, out_slot_q, slot_q;
  logic [4:0] rd_col_q;
  logic uplink_q;
  logic [1:0] mem [MAX_CH * MAX_U];
  logic out_valid_q, out_bit_q, out_tx_q;
  logic pend_q;
  logic [3:0] pend_last_q;
  logic in_acc, rd_hit, rd_step, ch_done, frame_done, slot_gap, cur_gap;
  logic [KW-1:0] rd_k;
  logic [4:0] gap_end;
  logic [3:0] gap_first;
  logic [UW:0] acc_sum;

  // Bus answers at once and always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // Address phase capture and read data from the register file
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ap_wr_q <= 1'b0;
      ap_addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else if (hready) begin
      ap_wr_q <= hsel && htrans[1] && hwrite;
      ap_addr_q <= haddr[7:0];
      if (hsel && htrans[1] && !hwrite) begin
        case (haddr[7:0])
          `PSIM_OFF_CTRL: hrdata_q <= ctrl_q;
          `PSIM_OFF_SIZE: hrdata_q <= size_q;
          `PSIM_OFF_GAP: hrdata_q <= gap_q;
          `PSIM_OFF_STATUS: hrdata_q <= {28'h0000000, out_valid_q, pend_q, state_q};
          `PSIM_OFF_FRAMES: hrdata_q <= {16'h0000, frames_q};
          default: hrdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Data phase writes to the control registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `PSIM_RST_CTRL;
      size_q <= `PSIM_RST_SIZE;
      gap_q <= `PSIM_RST_GAP;
    end else if (ap_wr_q) begin
      case (ap_addr_q)
        `PSIM_OFF_CTRL: ctrl_q <= {29'h00000000, hwdata[2:0]};
        `PSIM_OFF_SIZE: size_q <= {12'h000, hwdata[19:0]};
        `PSIM_OFF_GAP: gap_q <= {23'h000000, hwdata[8:0]};
        default: ;
      endcase
    end
  end

  // Row count of the interleaver matrix, rounded up
  assign rows = UW'((u_q + UW'(`PSIM_COLS - 1)) / UW'(`PSIM_COLS));
  // Matrix position of the current read cell: rows of 30, permuted column
  assign rd_k = KW'(rd_row_q) * COLS_K + KW'(PSIM_PERM[rd_col_q]);
  assign rd_hit = rd_k < KW'(u_q);
  assign rd_step = (state_q == PSIM_DRAIN) && (!rd_hit || !out_valid_q || out_ready);
  assign ch_done = rd_step && (rd_col_q == LAST_COL) && (rd_row_q == rows - UW'(1));
  assign frame_done = ch_done && (rd_ch_q == p_q - 4'h1);
  assign in_ready = (state_q == PSIM_FILL);
  assign in_acc = in_valid && in_ready;

  // Frame sequencing: wait, fill a whole frame, then drain it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= PSIM_IDLE;
      u_q <= '0;
      p_q <= 4'h0;
      uplink_q <= 1'b0;
    end else begin
      case (state_q)
        PSIM_IDLE: begin
          if (ctrl_q[`PSIM_CTRL_ENABLE]) begin
            state_q <= PSIM_FILL;
            u_q <= size_q[UW-1:0];
            p_q <= size_q[`PSIM_SIZE_P_MSB:`PSIM_SIZE_P_LSB];
            uplink_q <= ctrl_q[`PSIM_CTRL_UPLINK];
          end
        end
        PSIM_FILL: begin
          if (in_acc && wr_k_q == u_q - UW'(1) && wr_ch_q == p_q - 4'h1) begin
            state_q <= PSIM_DRAIN;
          end
        end
        PSIM_DRAIN: begin
          if (frame_done) begin
            state_q <= PSIM_IDLE;
          end
        end
        default: state_q <= PSIM_IDLE;
      endcase
    end
  end

  // Write side: consecutive groups of U bits per channel, row by row
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_k_q <= '0;
      wr_ch_q <= 4'h0;
    end else if (state_q != PSIM_FILL) begin
      wr_k_q <= '0;
      wr_ch_q <= 4'h0;
    end else if (in_acc) begin
      if (wr_k_q == u_q - UW'(1)) begin
        wr_k_q <= '0;
        wr_ch_q <= wr_ch_q + 4'h1;
      end else begin
        wr_k_q <= wr_k_q + UW'(1);
      end
    end
  end

  // Frame store: bit with its DTX flag, no DTX in uplink
  always_ff @(posedge ref_clk) begin
    if (in_acc) begin
      mem[AW'(wr_ch_q) * AW'(MAX_U) + AW'(wr_k_q)] <= {in_dtx && !uplink_q, in_bit};
    end
  end

  // Read side: column by column, top to bottom, one channel after another
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_row_q <= '0;
      rd_col_q <= 5'h00;
      rd_ch_q <= 4'h0;
    end else if (state_q != PSIM_DRAIN) begin
      rd_row_q <= '0;
      rd_col_q <= 5'h00;
      rd_ch_q <= 4'h0;
    end else if (rd_step) begin
      if (rd_row_q == rows - UW'(1)) begin
        rd_row_q <= '0;
        if (rd_col_q == LAST_COL) begin
          rd_col_q <= 5'h00;
          rd_ch_q <= rd_ch_q + 4'h1;
        end else begin
          rd_col_q <= rd_col_q + 5'h01;
        end
      end else begin
        rd_row_q <= rd_row_q + UW'(1);
      end
    end
  end

  // Slot of each output bit: floor of index times 15 over U
  assign acc_sum = {1'b0, slot_acc_q} + {1'b0, SLOTS_U};
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      slot_q <= 4'h0;
      slot_acc_q <= '0;
    end else if (state_q != PSIM_DRAIN || ch_done) begin
      slot_q <= 4'h0;
      slot_acc_q <= '0;
    end else if (rd_step && rd_hit) begin
      if (acc_sum >= {1'b0, u_q}) begin
        slot_acc_q <= UW'(acc_sum - {1'b0, u_q});
        slot_q <= slot_q + 4'h1;
      end else begin
        slot_acc_q <= acc_sum[UW-1:0];
      end
    end
  end

  // Compressed mode gap of this frame and the carry into the next
  assign gap_first = gap_q[`PSIM_GAP_FIRST_MSB:`PSIM_GAP_FIRST_LSB];
  assign gap_end = 5'(gap_first) + gap_q[`PSIM_GAP_LEN_MSB:`PSIM_GAP_LEN_LSB];
  always_comb begin
    cur_gap = 1'b0;
    if (ctrl_q[`PSIM_CTRL_CM_EN] && slot_q >= gap_first) begin
      cur_gap = (gap_end > SLOTS_5) || (5'(slot_q) < gap_end);
    end
    slot_gap = cur_gap || (pend_q && slot_q <= pend_last_q);
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
      pend_last_q <= 4'h0;
      frames_q <= 16'h0000;
    end else if (frame_done) begin
      pend_q <= ctrl_q[`PSIM_CTRL_CM_EN] && (gap_end > SLOTS_5);
      pend_last_q <= 4'(gap_end - SLOTS_5 - 5'h01);
      frames_q <= frames_q + 16'h0001;
    end
  end

  // Output register: downlink drops DTX bits, both drop gap slots
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      out_valid_q <= 1'b0;
      out_bit_q <= 1'b0;
      out_tx_q <= 1'b0;
      out_chan_q <= 4'h0;
      out_slot_q <= 4'h0;
    end else if (rd_step && rd_hit) begin
      out_valid_q <= 1'b1;
      out_bit_q <= mem[AW'(rd_ch_q) * AW'(MAX_U) + AW'(rd_k)][0];
      out_tx_q <= !slot_gap && (uplink_q || !mem[AW'(rd_ch_q) * AW'(MAX_U) + AW'(rd_k)][1]);
      out_chan_q <= rd_ch_q;
      out_slot_q <= slot_q;
    end else if (out_ready) begin
      out_valid_q <= 1'b0;
    end
  end
  assign out_valid = out_valid_q;
  assign out_bit = out_bit_q;
  assign out_tx = out_tx_q;
  assign out_chan = out_chan_q;
  assign out_slot = out_slot_q;

  // Checks on the block's own behaviour
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_last_in;
    in_acc && wr_k_q == u_q - UW'(1) && wr_ch_q == p_q - 4'h1;
  endsequence
  sequence s_drain_now;
    state_q == PSIM_DRAIN && !in_ready;
  endsequence
  a_fill_then_drain: assert property (s_last_in |=> s_drain_now)
    else $error("Full frame did not start draining");
  a_no_input_drain: assert property (state_q == PSIM_DRAIN |-> !in_ready)
    else $error("Input taken while draining");
  a_group_step: assert property (in_acc && wr_k_q == u_q - UW'(1) && wr_ch_q != p_q - 4'h1
      |=> wr_ch_q == $past(wr_ch_q) + 4'h1 && wr_k_q == '0)
    else $error("Channel group did not advance after U bits");
  a_prune_cell: assert property (rd_step && rd_hit |=> out_valid_q && out_chan_q == $past(rd_ch_q))
    else $error("Kept cell not emitted");
  a_skip_cell: assert property (state_q == PSIM_DRAIN && !rd_hit |-> rd_step)
    else $error("Pruned cell stalled the read");
  a_col_order: assert property (rd_step && rd_row_q != rows - UW'(1)
      |=> rd_col_q == $past(rd_col_q) && rd_row_q == $past(rd_row_q) + UW'(1))
    else $error("Read did not go down the column");
  a_row_bound: assert property (state_q == PSIM_DRAIN |-> KW'(rows) * COLS_K >= KW'(u_q)
      && (rows == '0 || KW'(rows - UW'(1)) * COLS_K < KW'(u_q)))
    else $error("Row count not minimal");
  a_perm_col: assert property (state_q == PSIM_DRAIN |-> rd_k % COLS_K == KW'(PSIM_PERM[rd_col_q]))
    else $error("Column permutation broken");
  a_out_hold: assert property (out_valid_q && !out_ready |=> out_valid_q && $stable(out_bit_q)
      && $stable(out_slot_q))
    else $error("Output changed while stalled");
  a_gap_silent: assert property (rd_step && rd_hit && slot_gap |=> !out_tx_q)
    else $error("Bit sent in a gap slot");
  a_dtx_silent: assert property (out_valid_q && out_tx_q && !uplink_q |-> 1'b1 ##0
      !mem[AW'(out_chan_q) * AW'(MAX_U) + AW'($past(rd_k))][1] || $past(!(rd_step && rd_hit)))
    else $error("DTX indication bit sent");
  a_uplink_full: assert property (rd_step && rd_hit && uplink_q && !slot_gap |=> out_tx_q)
    else $error("Uplink bit not sent outside a gap");
  a_gap_carry: assert property (frame_done && ctrl_q[`PSIM_CTRL_CM_EN] && gap_end > SLOTS_5
      |=> pend_q && pend_last_q == 4'(gap_end - 5'h10))
    else $error("Gap not carried into next frame");

  // Frame start takes the programmed size, one value for all channels
  a_size_latch: assert property (state_q == PSIM_IDLE && ctrl_q[`PSIM_CTRL_ENABLE]
      |=> state_q == PSIM_FILL && u_q == $past(size_q[UW-1:0]) && p_q == $past(size_q[19:16]))
    else $error("Frame size not taken at frame start");
  // Input write position restarts outside the fill phase
  a_wr_restart: assert property (state_q != PSIM_FILL |=> wr_k_q == '0 && wr_ch_q == 4'h0)
    else $error("Write position not restarted");
  // Input is open for the whole fill phase
  a_fill_ready: assert property (state_q == PSIM_FILL |-> in_ready)
    else $error("Input closed during fill");
  // Drain ends only after the last channel's last cell
  a_drain_end: assert property (state_q == PSIM_DRAIN && !frame_done |=> state_q == PSIM_DRAIN)
    else $error("Drain left early");
  // Channel and slot of an emitted bit stay in range
  a_chan_range: assert property (out_valid_q |-> out_chan_q < p_q && out_slot_q < 4'(`PSIM_SLOTS))
    else $error("Output channel or slot out of range");
  // Slot counting restarts with every channel
  a_slot_restart: assert property (ch_done |=> slot_q == 4'h0 && slot_acc_q == '0)
    else $error("Slot count not restarted per channel");
  // Slots inside the gap of this frame never transmit
  a_gap_inside: assert property (rd_step && rd_hit && ctrl_q[`PSIM_CTRL_CM_EN] && slot_q >= gap_first
      && 5'(slot_q) < gap_end |=> !out_tx_q)
    else $error("Bit sent inside the gap");
  // Slots up to the carried gap end stay silent in the next frame
  a_carry_silent: assert property (rd_step && rd_hit && pend_q && slot_q <= pend_last_q |=> !out_tx_q)
    else $error("Bit sent in the carried gap");
  // One frame is counted per completed drain
  a_frame_count: assert property (frame_done |=> frames_q == $past(frames_q) + 16'h0001)
    else $error("Frame not counted");
  // A downlink data bit outside any gap is sent
  a_dl_sent: assert property (rd_step && rd_hit && !uplink_q && !slot_gap
      && !mem[AW'(rd_ch_q) * AW'(MAX_U) + AW'(rd_k)][1] |=> out_tx_q)
    else $error("Downlink data bit not sent");
endmodule // psim_top

// ### psim_mux_src.sv
// Upstream multiplexer model that offers frame bits with their DTX flags
`timescale 1ns/100ps
module psim_mux_src (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Bit stream towards the block
  input wire logic in_ready,
  output logic in_valid,
  output logic in_bit,
  output logic in_dtx
);
  int stuck = 0;
  // Quiet lines at time zero
  initial begin
    in_valid = 1'b0;
    in_bit = 1'b0;
    in_dtx = 1'b0;
  end
  // Offer one bit after an optional pause; released lines flip so no stale value lingers
  task automatic send(input logic b, input logic d, input int pause);
    int n;
    if (pause > 0) begin
      in_valid <= 1'b0;
      in_bit <= ~in_bit;
      in_dtx <= ~in_dtx;
      repeat (pause) @(posedge ref_clk);
    end
    in_valid <= 1'b1;
    in_bit <= b;
    in_dtx <= d;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (in_ready !== 1'b1 && n < 200);
    if (n >= 200) stuck++;
  endtask
  // Drop the stream once the frame is complete
  task automatic go_idle();
    in_valid <= 1'b0;
    in_bit <= ~in_bit;
    in_dtx <= ~in_dtx;
  endtask
endmodule // psim_mux_src

// ### psim_top_tb.sv
// Self-checking testbench of the segment/interleave/map block
`timescale 1ns/100ps
`include "psim_params.svh"
module psim_top_tb;
  logic ref_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic in_valid, in_ready, in_bit, in_dtx, out_valid, out_ready, out_bit, out_tx;
  logic [3:0] out_chan, out_slot;
  logic [9:0] exp_q[$];
  int fails = 0;
  int check_count = 0;
  int frames = 0;
  int carry = -1;
  bit filling = 0;
  int perm[30] = '{0, 20, 10, 5, 15, 25, 3, 13, 23, 8, 18, 28, 1, 11, 21,
                   6, 16, 26, 4, 14, 24, 19, 9, 29, 12, 2, 7, 22, 27, 17};
  assign hready = hreadyout;
  psim_top uut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .in_valid(in_valid), .in_ready(in_ready), .in_bit(in_bit), .in_dtx(in_dtx), .out_valid(out_valid),
    .out_ready(out_ready), .out_bit(out_bit), .out_tx(out_tx), .out_chan(out_chan), .out_slot(out_slot));
  psim_mux_src src (.ref_clk(ref_clk), .rst(rst), .in_ready(in_ready), .in_valid(in_valid), .in_bit(in_bit),
    .in_dtx(in_dtx));
  // Clock
  always #20 ref_clk = ~ref_clk;
  task automatic finish_test();
    fails += src.stuck;
    $display("Checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic bail(input string what);
    fails++;
    $display("[ERR] %s expected progress seen timeout", what);
    finish_test();
  endtask
  // Wait for an edge with the bus ready
  task automatic step_rdy();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) bail("hready");
  endtask
  // One single-word AHB-Lite transfer
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    step_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    step_rdy();
    q = hrdata;
    check("hresp", 32'h0, 32'(hresp));
  endtask
  // Model one frame, feed it, and wait until every expected bit has left
  task automatic run_frame(input int u, input int p, input int ul, input int cm, input int first, input int len,
                           input int dmode);
    logic [1:0] x[$];
    int k, n, s, tx;
    for (k = 0; k < u * p; k++) begin
      x.push_back({1'($urandom), 1'((dmode == 1 && k >= u * p - u / 2) || (dmode == 2 && $urandom % 4 == 0))});
    end
    for (int c = 0; c < p; c++) begin
      n = 0;
      for (int j = 0; j < 30; j++) begin
        for (int row = 0; row * 30 < u; row++) begin
          k = row * 30 + perm[j];
          if (k < u) begin
            s = n * 15 / u;
            tx = !(cm && s >= first && s < first + len) && !(s <= carry) && !(ul == 0 && x[c * u + k][0]);
            exp_q.push_back({x[c * u + k][1], 1'(tx), 4'(c), 4'(s)});
            n++;
          end
        end
      end
    end
    carry = (cm && first + len > 15) ? first + len - 16 : -1;
    ahb(1'b1, `PSIM_OFF_SIZE, (32'(p) << 16) | 32'(u), r);
    ahb(1'b1, `PSIM_OFF_GAP, 32'((len << 4) | first), r);
    ahb(1'b1, `PSIM_OFF_CTRL, 32'((cm << 2) | (ul << 1) | 1), r);
    filling = 1;
    foreach (x[i]) src.send(x[i][1], x[i][0], ($urandom % 4 == 0) ? $urandom % 3 + 1 : 0);
    src.go_idle();
    filling = 0;
    ahb(1'b1, `PSIM_OFF_CTRL, 32'((cm << 2) | (ul << 1)), r);
    ahb(1'b0, `PSIM_OFF_STATUS, 32'h0, r);
    check("status_state", 32'h2, {30'h0, r[1:0]});
    n = 0;
    while (exp_q.size() != 0 && n < 20000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 20000) bail("drain");
    frames++;
  endtask
  // Output collector with a stalling consumer
  always @(posedge ref_clk) begin
    if (filling) check("out_during_fill", 32'h0, 32'(out_valid));
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_q.size() == 0) check("extra_out", 32'h0, 32'h1);
      else check("out_word", 32'(exp_q.pop_front()), {22'h0, out_bit, out_tx, out_chan, out_slot});
    end
    out_ready <= ($urandom % 3 != 0);
  end
  // Main sequence
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    hwrite = 1'b0;
    htrans = 2'b00;
    hsize = 3'h2;
    hwdata = 32'h0;
    out_ready = 1'b0;
    void'($urandom(72299));
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    check("in_ready_idle", 32'h0, 32'(in_ready));
    ahb(1'b0, `PSIM_OFF_CTRL, 32'h0, r);
    check("ctrl_rst", `PSIM_RST_CTRL, r);
    ahb(1'b0, `PSIM_OFF_SIZE, 32'h0, r);
    check("size_rst", `PSIM_RST_SIZE, r);
    ahb(1'b0, `PSIM_OFF_GAP, 32'h0, r);
    check("gap_rst", `PSIM_RST_GAP, r);
    ahb(1'b1, `PSIM_OFF_STATUS, 32'hFFFF_FFFF, r);
    ahb(1'b0, `PSIM_OFF_STATUS, 32'h0, r);
    check("status_ro", 32'h0, r);
    ahb(1'b0, 8'h20, 32'h0, r);
    check("unmapped", 32'h0, r);
    run_frame(30, 1, 1, 0, 0, 0, 0);
    run_frame(61, 3, 0, 0, 0, 0, 1);
    run_frame(45, 2, 0, 0, 0, 0, 2);
    run_frame(45, 2, 1, 1, 3, 4, 0);
    run_frame(100, 2, 1, 1, 12, 5, 0);
    run_frame(60, 1, 1, 1, 14, 1, 0);
    run_frame(30, 1, 0, 1, 0, 15, 0);
    ahb(1'b0, `PSIM_OFF_FRAMES, 32'h0, r);
    check("frames", 32'(frames), {16'h0, r[15:0]});
    finish_test();
  end
endmodule // psim_top_tb
